/* rtl/fifo_port_pkg.sv */
// constants and types shared by the port control block and its data buffer
package fifo_port_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // data path
  localparam int DATA_WIDTH     = 36;
  localparam int MEMORY_DEPTH   = 256;
  localparam int BUFFER_DEPTH   = 8;
  localparam int OFFSET_BITS    = 8;

  //////////////////////////////////////////////////////////////////////////////
  // offset presets selected at the end of a master reset
  localparam logic [9:0] OFFSET_PRESET_HIGH = 10'h040;
  localparam logic [9:0] OFFSET_PRESET_MID  = 10'h010;
  localparam logic [9:0] OFFSET_PRESET_LOW  = 10'h008;
  localparam logic [9:0] OFFSET_RESET_VALUE = 10'h040;

  // {serial select_n, flag select one, flag select zero} latched at reset release
  localparam logic [2:0] SELECT_PRESET_HIGH = 3'h7;
  localparam logic [2:0] SELECT_PRESET_MID  = 3'h6;
  localparam logic [2:0] SELECT_PRESET_LOW  = 3'h5;
  localparam logic [2:0] SELECT_PARALLEL    = 3'h4;
  localparam logic [2:0] SELECT_SERIAL      = 3'h2;

  //////////////////////////////////////////////////////////////////////////////
  // offset programming sequence
  typedef enum logic [1:0]
  {
    PROG_DONE     = 2'b00,
    PROG_PAR_FULL = 2'b01,
    PROG_PAR_EMPTY = 2'b10,
    PROG_SERIAL   = 2'b11
  } prog_state_type;

endpackage

/* rtl/fifo_data_buffer.sv */
// synchronous data buffer with valid/ready on both sides and a fill count
`timescale 1ns/10ps
module fifo_data_buffer
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
)
(
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       clockEnable,
  input  wire logic                       clear,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic      [WIDTH-1:0]           outData,
  output logic      [$clog2(DEPTH+1)-1:0] fillCount
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  logic [WIDTH-1:0] memory [DEPTH];
  logic [PW-1:0]    writePtr_reg;
  logic [PW-1:0]    readPtr_reg;
  logic [CW-1:0]    count_reg;
  logic             pushing;
  logic             popping;

  assign inReady   = (count_reg != FULL_COUNT);
  assign outValid  = (count_reg != '0);
  assign outData   = memory[readPtr_reg];
  assign fillCount = count_reg;
  assign pushing   = inValid & inReady;
  assign popping   = outReady & outValid;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (clockEnable && pushing)
    begin
      memory[writePtr_reg] <= inData;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset || (clockEnable && clear))
    begin
      writePtr_reg <= '0;
      readPtr_reg  <= '0;
      count_reg    <= '0;
    end
    else if (clockEnable)
    begin
      if (pushing)
      begin
        writePtr_reg <= (writePtr_reg == LAST_SLOT) ? '0 : writePtr_reg + 1'b1;
      end
      if (popping)
      begin
        readPtr_reg <= (readPtr_reg == LAST_SLOT) ? '0 : readPtr_reg + 1'b1;
      end
      if (pushing && !popping)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (popping && !pushing)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

/* rtl/fifo_port_control.sv */
// port control, offset programming, flags and mailboxes of the one-way fifo
//
// Summary of operation
// - serial select high at reset release loads presets 64, 16 or 8.
// - serial select high with both flag selects low selects parallel programming.
// - parallel mode: first two writes load full then empty offset, third stores data.
// - parallel offsets come from the low write data bits, top bit most significant.
// - serial mode needs select low, data low, enable high; other low combos reserved.
// - serial mode shifts one data bit per clock while serial enable is low.
// - serial load takes two offsets of bits, full offset first then empty.
// - input ready stays low during serial load, rises the edge after last bit.
// - write port drives its data only while select and direction are both low.
// - fifo write needs select low, direction high, enable, no mail, input ready.
// - read port drives data when select low and direction high, else released.
// - fifo read needs select low, direction high, enable, no mail, output ready.
// - with a port enable low that port makes no fifo or mail access; its data drive still follows select and direction.
// - fall-through with output ready low loads next word automatically.
// - otherwise words reach the output register only on a full read request.
// - almost flags pass two flop stages, full and empty flags three; full side and empty side kept apart.
// - write port mail select writes mail one or reads mail two, freeing it.
// - read port mail select reads mail one, freeing it, or writes mail two.
// - after reset release the select pin picks standard (high) or fall-through (low).
// - reset release latches flag selects and serial select for programming.
`timescale 1ns/10ps
module fifo_port_control
#(
  parameter int DEPTH       = fifo_port_pkg::MEMORY_DEPTH,
  parameter int OFFSET_BITS = fifo_port_pkg::OFFSET_BITS
)
(
  input  wire logic                                clock,
  input  wire logic                                reset,
  input  wire logic                                clockEnable,
  input  wire logic                                master_reset_n,
  input  wire logic                                serial_prog_select_n,
  input  wire logic                                flag_sel0_serial_data,
  input  wire logic                                flag_sel1_serial_enable_n,
  input  wire logic                                endian_fallthrough_sel,
  input  wire logic                                write_port_select_n,
  input  wire logic                                write_port_dir,
  input  wire logic                                write_port_enable,
  input  wire logic                                write_port_mail_sel,
  input  wire logic [fifo_port_pkg::DATA_WIDTH-1:0] writeDataIn,
  output logic      [fifo_port_pkg::DATA_WIDTH-1:0] writeDataOut,
  output logic                                     writeDataOe,
  input  wire logic                                read_port_select_n,
  input  wire logic                                read_port_dir,
  input  wire logic                                read_port_enable,
  input  wire logic                                read_port_mail_sel,
  input  wire logic [fifo_port_pkg::DATA_WIDTH-1:0] readDataIn,
  output logic      [fifo_port_pkg::DATA_WIDTH-1:0] readDataOut,
  output logic                                     readDataOe,
  output logic                                     full_or_input_ready,
  output logic                                     empty_or_output_ready,
  output logic                                     almost_empty_n,
  output logic                                     almost_full_n,
  output logic                                     mail_one_flag_n,
  output logic                                     mail_two_flag_n,
  output logic                                     fall_through_mode,
  output logic      [OFFSET_BITS-1:0]              almostEmptyOffset,
  output logic      [OFFSET_BITS-1:0]              almostFullOffset
);

  localparam int DW = fifo_port_pkg::DATA_WIDTH;
  localparam int CW = $clog2(DEPTH+1);
  localparam int SW = $clog2(2*OFFSET_BITS+1);
  localparam logic [SW-1:0] LAST_SERIAL_BIT = SW'(2*OFFSET_BITS - 1);
  localparam logic [CW-1:0] DEPTH_COUNT = CW'(DEPTH);

  function automatic logic [OFFSET_BITS-1:0] fitOffset(input logic [9:0] value);
    fitOffset = OFFSET_BITS'(value);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  fifo_port_pkg::prog_state_type progState_reg;
  logic                 masterResetPrev_reg;
  logic                 modeWait_reg;
  logic [SW-1:0]        serialCount_reg;
  logic [OFFSET_BITS-1:0] emptyOffset_reg;
  logic [OFFSET_BITS-1:0] fullOffset_reg;
  logic                 fullSync0_reg;
  logic                 fullSync1_reg;
  logic                 full_reg;
  logic                 nearFullSync0_reg;
  logic                 nearFullSync1_reg;
  logic                 emptySync0_reg;
  logic                 emptySync1_reg;
  logic                 emptyFlag_reg;
  logic                 emptyFlag_next;
  logic                 nearEmptySync0_reg;
  logic                 nearEmptySync1_reg;
  logic                 fallThrough_reg;
  logic [DW-1:0]        outWord_reg;
  logic [DW-1:0]        mailOne_reg;
  logic [DW-1:0]        mailTwo_reg;
  logic                 mailOneFlag_reg;
  logic                 mailTwoFlag_reg;
  logic [DW-1:0]        writeDataOut_reg;
  logic                 writeDataOe_reg;
  logic [DW-1:0]        readDataOut_reg;
  logic                 readDataOe_reg;
  logic                 resetRise;
  logic                 writeSelected;
  logic                 readSelected;
  logic                 dataWriteCycle;
  logic                 fifoWrite;
  logic                 progWrite;
  logic                 fifoReadRequest;
  logic                 fifoPop;
  logic                 mailOneWrite;
  logic                 mailOneRead;
  logic                 mailTwoWrite;
  logic                 mailTwoRead;
  logic                 bufferInReady;
  logic                 bufferOutValid;
  logic [DW-1:0]        bufferOutData;
  logic [CW-1:0]        fillCount;

  //////////////////////////////////////////////////////////////////////////////
  // port decode
  assign resetRise      = master_reset_n & ~masterResetPrev_reg;
  assign writeSelected  = ~write_port_select_n & write_port_enable & master_reset_n;
  assign readSelected   = ~read_port_select_n & read_port_enable & master_reset_n;
  assign dataWriteCycle = writeSelected & write_port_dir & ~write_port_mail_sel & full_reg;
  assign fifoWrite      = dataWriteCycle & (progState_reg == fifo_port_pkg::PROG_DONE)
                          & bufferInReady;
  assign progWrite      = dataWriteCycle & ((progState_reg == fifo_port_pkg::PROG_PAR_FULL)
                          | (progState_reg == fifo_port_pkg::PROG_PAR_EMPTY));
  assign fifoReadRequest = readSelected & read_port_dir & ~read_port_mail_sel;
  assign mailOneWrite   = writeSelected & write_port_dir & write_port_mail_sel;
  assign mailTwoRead    = writeSelected & ~write_port_dir & write_port_mail_sel;
  assign mailOneRead    = readSelected & read_port_dir & read_port_mail_sel;
  assign mailTwoWrite   = readSelected & ~read_port_dir & read_port_mail_sel;

  // fall-through pulls a word with no request while output ready is low
  always_comb
  begin
    fifoPop        = 1'b0;
    emptyFlag_next = emptyFlag_reg;
    if (fallThrough_reg)
    begin
      if (!emptyFlag_reg)
      begin
        fifoPop        = emptySync1_reg & bufferOutValid;
        emptyFlag_next = fifoPop;
      end
      else if (fifoReadRequest)
      begin
        fifoPop        = emptySync1_reg & bufferOutValid;
        emptyFlag_next = fifoPop;
      end
    end
    else
    begin
      fifoPop        = fifoReadRequest & emptyFlag_reg & bufferOutValid;
      emptyFlag_next = emptySync1_reg & ~(fifoPop & (fillCount == CW'(1)));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data buffer
  fifo_data_buffer
  #(
    .WIDTH (DW),
    .DEPTH (DEPTH)
  )
  dataBuffer
  (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .clear       (~master_reset_n),
    .inValid     (fifoWrite),
    .inReady     (bufferInReady),
    .inData      (writeDataIn),
    .outValid    (bufferOutValid),
    .outReady    (fifoPop),
    .outData     (bufferOutData),
    .fillCount   (fillCount)
  );

  //////////////////////////////////////////////////////////////////////////////
  // reset release and timing mode
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      masterResetPrev_reg <= 1'b0;
      modeWait_reg        <= 1'b0;
      fallThrough_reg     <= 1'b0;
    end
    else if (clockEnable)
    begin
      masterResetPrev_reg <= master_reset_n;
      modeWait_reg        <= resetRise;
      if (modeWait_reg)
      begin
        fallThrough_reg <= ~endian_fallthrough_sel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // offset programming
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      progState_reg   <= fifo_port_pkg::PROG_DONE;
      serialCount_reg <= '0;
      emptyOffset_reg <= fitOffset(fifo_port_pkg::OFFSET_RESET_VALUE);
      fullOffset_reg  <= fitOffset(fifo_port_pkg::OFFSET_RESET_VALUE);
    end
    else if (clockEnable)
    begin
      if (resetRise)
      begin
        serialCount_reg <= '0;
        progState_reg   <= fifo_port_pkg::PROG_DONE;
        case ({serial_prog_select_n, flag_sel1_serial_enable_n, flag_sel0_serial_data})
          fifo_port_pkg::SELECT_PRESET_HIGH:
          begin
            emptyOffset_reg <= fitOffset(fifo_port_pkg::OFFSET_PRESET_HIGH);
            fullOffset_reg  <= fitOffset(fifo_port_pkg::OFFSET_PRESET_HIGH);
          end
          fifo_port_pkg::SELECT_PRESET_MID:
          begin
            emptyOffset_reg <= fitOffset(fifo_port_pkg::OFFSET_PRESET_MID);
            fullOffset_reg  <= fitOffset(fifo_port_pkg::OFFSET_PRESET_MID);
          end
          fifo_port_pkg::SELECT_PRESET_LOW:
          begin
            emptyOffset_reg <= fitOffset(fifo_port_pkg::OFFSET_PRESET_LOW);
            fullOffset_reg  <= fitOffset(fifo_port_pkg::OFFSET_PRESET_LOW);
          end
          fifo_port_pkg::SELECT_PARALLEL:
          begin
            progState_reg <= fifo_port_pkg::PROG_PAR_FULL;
          end
          fifo_port_pkg::SELECT_SERIAL:
          begin
            progState_reg <= fifo_port_pkg::PROG_SERIAL;
          end
          default:
          begin
            progState_reg <= fifo_port_pkg::PROG_DONE;
          end
        endcase
      end
      else if (master_reset_n)
      begin
        case (progState_reg)
          fifo_port_pkg::PROG_PAR_FULL:
          begin
            if (progWrite)
            begin
              fullOffset_reg <= writeDataIn[OFFSET_BITS-1:0];
              progState_reg  <= fifo_port_pkg::PROG_PAR_EMPTY;
            end
          end
          fifo_port_pkg::PROG_PAR_EMPTY:
          begin
            if (progWrite)
            begin
              emptyOffset_reg <= writeDataIn[OFFSET_BITS-1:0];
              progState_reg   <= fifo_port_pkg::PROG_DONE;
            end
          end
          fifo_port_pkg::PROG_SERIAL:
          begin
            if (!flag_sel1_serial_enable_n)
            begin
              {fullOffset_reg, emptyOffset_reg} <=
                {fullOffset_reg[OFFSET_BITS-2:0], emptyOffset_reg, flag_sel0_serial_data};
              serialCount_reg <= serialCount_reg + 1'b1;
              if (serialCount_reg == LAST_SERIAL_BIT)
              begin
                progState_reg <= fifo_port_pkg::PROG_DONE;
              end
            end
          end
          default:
          begin
            progState_reg <= fifo_port_pkg::PROG_DONE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write side flags
  always_ff @(posedge clock)
  begin
    if (reset || (clockEnable && !master_reset_n))
    begin
      fullSync0_reg <= 1'b0;
      fullSync1_reg <= 1'b0;
      full_reg      <= 1'b0;
      nearFullSync0_reg <= 1'b1;
      nearFullSync1_reg <= 1'b1;
    end
    else if (clockEnable)
    begin
      fullSync0_reg <= bufferInReady;
      fullSync1_reg <= fullSync0_reg;
      full_reg      <= fullSync1_reg & (progState_reg != fifo_port_pkg::PROG_SERIAL);
      nearFullSync0_reg <= (fillCount < (DEPTH_COUNT - CW'(fullOffset_reg)));
      nearFullSync1_reg <= nearFullSync0_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read side flags and output register
  always_ff @(posedge clock)
  begin
    if (reset || (clockEnable && !master_reset_n))
    begin
      emptySync0_reg <= 1'b0;
      emptySync1_reg <= 1'b0;
      emptyFlag_reg  <= 1'b0;
      nearEmptySync0_reg <= 1'b0;
      nearEmptySync1_reg <= 1'b0;
    end
    else if (clockEnable)
    begin
      emptySync0_reg <= bufferOutValid & ~fifoPop;
      emptySync1_reg <= emptySync0_reg & bufferOutValid & ~fifoPop;
      emptyFlag_reg  <= emptyFlag_next;
      nearEmptySync0_reg <= (fillCount > CW'(emptyOffset_reg));
      nearEmptySync1_reg <= nearEmptySync0_reg;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      outWord_reg <= '0;
    end
    else if (clockEnable && fifoPop)
    begin
      outWord_reg <= bufferOutData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mailboxes; a write in the same cycle as the freeing read leaves new mail flagged
  always_ff @(posedge clock)
  begin
    if (reset || (clockEnable && !master_reset_n))
    begin
      mailOne_reg     <= '0;
      mailTwo_reg     <= '0;
      mailOneFlag_reg <= 1'b1;
      mailTwoFlag_reg <= 1'b1;
    end
    else if (clockEnable)
    begin
      if (mailOneWrite)
      begin
        mailOne_reg     <= writeDataIn;
        mailOneFlag_reg <= 1'b0;
      end
      else if (mailOneRead)
      begin
        mailOneFlag_reg <= 1'b1;
      end
      if (mailTwoWrite)
      begin
        mailTwo_reg     <= readDataIn;
        mailTwoFlag_reg <= 1'b0;
      end
      else if (mailTwoRead)
      begin
        mailTwoFlag_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data pin drivers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      writeDataOut_reg <= '0;
      writeDataOe_reg  <= 1'b0;
      readDataOut_reg  <= '0;
      readDataOe_reg   <= 1'b0;
    end
    else if (clockEnable)
    begin
      writeDataOut_reg <= mailTwo_reg;
      writeDataOe_reg  <= ~write_port_select_n & ~write_port_dir;
      readDataOut_reg  <= read_port_mail_sel ? mailOne_reg : outWord_reg;
      readDataOe_reg   <= ~read_port_select_n & read_port_dir;
    end
  end

  assign writeDataOut          = writeDataOut_reg;
  assign writeDataOe           = writeDataOe_reg;
  assign readDataOut           = readDataOut_reg;
  assign readDataOe            = readDataOe_reg;
  assign full_or_input_ready   = full_reg;
  assign empty_or_output_ready = emptyFlag_reg;
  assign almost_empty_n        = nearEmptySync1_reg;
  assign almost_full_n         = nearFullSync1_reg;
  assign mail_one_flag_n       = mailOneFlag_reg;
  assign mail_two_flag_n       = mailTwoFlag_reg;
  assign fall_through_mode     = fallThrough_reg;
  assign almostEmptyOffset     = emptyOffset_reg;
  assign almostFullOffset      = fullOffset_reg;

endmodule

/* bench/fifo_port_chk.sv */
// pin-level checks on the port control block
`timescale 1ns/10ps
module fifo_port_chk
(
  input wire logic clock,
  input wire logic reset,
  input wire logic master_reset_n,
  input wire logic write_port_select_n,
  input wire logic write_port_dir,
  input wire logic write_port_enable,
  input wire logic write_port_mail_sel,
  input wire logic writeDataOe,
  input wire logic read_port_select_n,
  input wire logic read_port_dir,
  input wire logic read_port_enable,
  input wire logic read_port_mail_sel,
  input wire logic readDataOe,
  input wire logic mail_one_flag_n,
  input wire logic mail_two_flag_n
);
  wire mailA = !write_port_select_n && write_port_enable && write_port_mail_sel && master_reset_n;
  wire mailB = !read_port_select_n && read_port_enable && read_port_mail_sel && master_reset_n;
  wire m1Wr = mailA && write_port_dir;
  wire m2Rd = mailA && !write_port_dir;
  wire m1Rd = mailB && read_port_dir;
  wire m2Wr = mailB && !read_port_dir;
  wire driveA = !write_port_select_n && !write_port_dir;
  wire driveB = !read_port_select_n && read_port_dir;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_write_oe: assert property (!$past(reset) |-> writeDataOe == $past(driveA))
    else $error("write port drive wrong");
  chk_read_oe: assert property (!$past(reset) |-> readDataOe == $past(driveB))
    else $error("read port drive wrong");
  chk_mail_one_set: assert property (m1Wr |=> !mail_one_flag_n)
    else $error("mail one flag not set");
  chk_mail_two_free: assert property (m2Rd && !m2Wr |=> mail_two_flag_n)
    else $error("mail two flag not freed");
  chk_mail_one_free: assert property (m1Rd && !m1Wr |=> mail_one_flag_n)
    else $error("mail one flag not freed");
  chk_mail_two_set: assert property (m2Wr |=> !mail_two_flag_n)
    else $error("mail two flag not set");
  chk_mail_one_cause: assert property ($fell(mail_one_flag_n) |-> $past(m1Wr))
    else $error("mail one flag fell without a write");
  chk_idle_ports: assert property (master_reset_n && !write_port_enable && !read_port_enable
    |=> $stable(mail_one_flag_n) && $stable(mail_two_flag_n)) else $error("flag moved while idle");
  cover property (m1Wr);
  cover property (m1Rd);
  cover property (m2Rd);
endmodule
bind fifo_port_control fifo_port_chk u_chk (.*);

/* bench/fifo_reader_model.sv */
// bus master model on the read port: fifo reads and mailbox accesses
`timescale 1ns/10ps
module fifo_reader_model
#(
  parameter logic [35:0] MAIL_WORD = 36'hC3C3C3C3C
)
(
  input wire logic        clock,
  input wire logic        go,
  input wire logic [1:0]  mailOp,
  input wire logic        ready,
  input wire logic [35:0] dataOut,
  output logic            selectN = 1'b1,
  output logic            dir = 1'b1,
  output logic            enable = 1'b0,
  output logic            mailSel = 1'b0,
  output logic     [35:0] dataIn = 36'h0,
  output logic            got = 1'b0,
  output logic     [35:0] word = 36'h0
);
  logic [1:0] waitCount = 2'h0;
  // released data lines toggle every cycle; a read result is taken two edges after the pop
  always @(posedge clock) begin
    got <= 1'b0;
    dataIn <= ~dataIn;
    if (enable && (mailSel || ready || !go)) begin
      enable <= 1'b0;
      selectN <= 1'b1;
      waitCount <= (mailSel ? dir : ready) ? 2'h2 : 2'h0;
    end else if (!enable && waitCount != 2'h0) begin
      waitCount <= waitCount - 2'h1;
      got <= waitCount == 2'h1;
      word <= dataOut;
    end else if (!enable && (go || mailOp != 2'h0)) begin
      enable <= 1'b1;
      selectN <= 1'b0;
      mailSel <= mailOp != 2'h0;
      dir <= mailOp != 2'h1;
      if (mailOp == 2'h1)
        dataIn <= MAIL_WORD;
    end
  end
endmodule

/* bench/fifo_port_control_test.sv */
// self-checking bench for the port control block
`timescale 1ns/10ps
module fifo_port_control_test;
  localparam logic [35:0] MAIL = 36'hC3C3C3C3C;
  logic clock, reset, mrN, spN, sel0, sel1, endSel, aSelN, aDir, aEn, aMail, go;
  logic bSelN, bDir, bEn, bMail, got, aOe, bOe, fir, eor, m1N, m2N, ftm, nearEmpty, nearFull;
  logic [1:0] mOp;
  logic [7:0] emptyOff, fullOff;
  logic [35:0] aIn, aOut, bIn, bOut, word, expQ[$];
  logic [7:0] pv[3] = '{8'h40, 8'h10, 8'h08};
  logic [15:0] bits = 16'h9C21;
  int errors = 0, n_checks = 0;
  fifo_port_control u_dut (.clock(clock), .reset(reset), .clockEnable(1'b1), .master_reset_n(mrN),
    .serial_prog_select_n(spN), .flag_sel0_serial_data(sel0), .flag_sel1_serial_enable_n(sel1),
    .endian_fallthrough_sel(endSel), .write_port_select_n(aSelN), .write_port_dir(aDir),
    .write_port_enable(aEn), .write_port_mail_sel(aMail), .writeDataIn(aIn), .writeDataOut(aOut),
    .writeDataOe(aOe), .read_port_select_n(bSelN), .read_port_dir(bDir), .read_port_enable(bEn),
    .read_port_mail_sel(bMail), .readDataIn(bIn), .readDataOut(bOut), .readDataOe(bOe),
    .full_or_input_ready(fir), .empty_or_output_ready(eor), .almost_empty_n(nearEmpty),
    .almost_full_n(nearFull),
    .mail_one_flag_n(m1N), .mail_two_flag_n(m2N), .fall_through_mode(ftm),
    .almostEmptyOffset(emptyOff), .almostFullOffset(fullOff));
  fifo_reader_model #(.MAIL_WORD(MAIL)) u_far (.clock(clock), .go(go), .mailOp(mOp), .ready(eor),
    .dataOut(bOut), .selectN(bSelN), .dir(bDir), .enable(bEn), .mailSel(bMail), .dataIn(bIn),
    .got(got), .word(word));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task chk(input logic [35:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // request held until taken; mail accesses need no free space
  task acc(input logic dir, mail, input logic [35:0] d);
    int n;
    logic ok;
    {aSelN, aEn, aDir, aMail, aIn} <= {2'b01, dir, mail, d};
    n = 0;
    do begin
      @(negedge clock);
      ok = mail || fir;
      n++;
      @(posedge clock);
    end while (!ok && n < 900);
    if (!ok) begin
      errors++;
      end_sim;
    end
  endtask
  task rel;
    aEn <= 1'b0;
    aSelN <= 1'b1;
    aIn <= ~aIn;
  endtask
  task mres(input logic [2:0] s, input logic std);
    @(posedge clock);
    {mrN, spN, sel1, sel0, endSel} <= {1'b0, s, std};
    repeat (2) @(posedge clock);
    mrN <= 1'b1;
    repeat (5) @(posedge clock);
  endtask
  always @(negedge clock)
    if (got)
      chk(word, expQ.pop_front());
  initial begin
    {reset, mrN, spN, sel1, sel0, endSel, aSelN, aDir, aEn, aMail, go, mOp, aIn} = {11'h5F8, 38'h0};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      mres(3'h7 - 3'(i), i[0]);
      chk(36'(fullOff), 36'(pv[i]));
      chk(36'(emptyOff), 36'(pv[i]));
      chk(36'(ftm), 36'(!i[0]));
    end
    $display("preset test done");
    mres(3'h2, 1'b1);
    for (int i = 0; i < 17; i++) begin
      {sel1, sel0} <= (i < 16) ? {1'b0, bits[15 - i]} : 2'b10;
      @(negedge clock);
      chk(36'(fir), 36'h0);
      @(posedge clock);
    end
    @(negedge clock);
    chk(36'(fir), 36'h1);
    chk(36'(fullOff), 36'h9C);
    chk(36'(emptyOff), 36'h21);
    $display("serial test done");
    mres(3'h4, 1'b1);
    acc(1'b1, 1'b0, 36'hABCDEF00C);
    acc(1'b1, 1'b0, 36'h123456703);
    for (int i = 0; i < 256; i++) begin
      acc(1'b1, 1'b0, 36'(i));
      expQ.push_back(36'(i));
    end
    rel;
    repeat (4) @(posedge clock);
    {aSelN, aEn, aIn} <= {2'b01, 36'hFFFFFFFFF};
    @(negedge clock);
    chk(36'(fir), 36'h0);
    chk(36'({fullOff, emptyOff}), 36'h0C03);
    chk(36'({nearEmpty, nearFull}), 36'h2);
    repeat (3) @(posedge clock);
    rel;
    go <= 1'b1;
    for (int n = 0; n < 2000 && expQ.size() != 0; n++)
      @(posedge clock);
    repeat (8) @(posedge clock);
    go <= 1'b0;
    @(negedge clock);
    chk(36'(expQ.size() != 0 || eor), 36'h0);
    chk(36'({nearEmpty, nearFull}), 36'h1);
    $display("fill and drain test done");
    @(posedge clock);
    acc(1'b1, 1'b1, 36'h5A5A5A5A5);
    rel;
    @(negedge clock);
    chk(36'(m1N), 36'h0);
    expQ.push_back(36'h5A5A5A5A5);
    for (int k = 2; k > 0; k--) begin
      @(posedge clock);
      mOp <= 2'(k);
      @(posedge clock);
      mOp <= 2'h0;
      repeat (3) @(posedge clock);
    end
    chk(36'({m1N, m2N}), 36'h2);
    acc(1'b0, 1'b1, 36'h0);
    rel;
    @(negedge clock);
    chk(36'(m2N), 36'h1);
    chk(aOut, MAIL);
    $display("mail test done");
    mres(3'h3, 1'b0);
    chk(36'({fullOff, emptyOff, ftm}), 36'h1807);
    expQ.push_back(36'h0F0F0F0F0);
    acc(1'b1, 1'b0, 36'h0F0F0F0F0);
    rel;
    repeat (6) @(posedge clock);
    chk(36'(eor), 36'h1);
    go <= 1'b1;
    repeat (2) @(posedge clock);
    go <= 1'b0;
    repeat (4) @(negedge clock);
    chk(36'({eor, expQ.size() != 0}), 36'h0);
    $display("fall-through test done");
    end_sim;
  end
endmodule
